// [pkg/nv_access_pkg.sv]
// Purpose: Shared constants for the byte-wide data EEPROM access block.
// Assumes: 20 MHz CPU clock, calibrated oscillator delivered as a tick level.
// Notes: Register indices are I/O addresses of the access block.
package nv_access_pkg;
    localparam int CLOCK_NS = 50;
    // Register map
    localparam logic [5:0] REG_ADDR_HIGH = 6'h03;
    localparam logic [5:0] REG_ADDR_LOW = 6'h02;
    localparam logic [5:0] REG_DATA = 6'h01;
    localparam logic [5:0] REG_CONTROL = 6'h00;
    // Control field positions
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_PROGRAM_STROBE = 1;
    localparam int BIT_PROGRAM_ARM = 2;
    localparam int BIT_READY_IRQ_ENABLE = 3;
    localparam int BIT_PROG_MODE_LO = 4;
    localparam int BIT_PROG_MODE_HI = 5;
    // Programming modes
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h0;
    // Stall and arm window lengths in CPU cycles
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
    localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
    localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
    // Programming times, timed from the calibrated oscillator
    localparam int TIME_ATOMIC_NS = 3_400_000;
    localparam int TIME_SPLIT_NS = 1_800_000;
    localparam int OSC_TICK_NS = 1000;
    localparam int ATOMIC_TICKS = TIME_ATOMIC_NS / OSC_TICK_NS;
    localparam int SPLIT_TICKS = TIME_SPLIT_NS / OSC_TICK_NS;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// [core/nv_byte_access.sv]
// Purpose: CPU-side access block of the data EEPROM: address, data, control.
// Assumes: I/O strobes are single-cycle and synchronous to clock.
// Notes: Programming engine and array survive reset_n, except that an idle engine's mode clears; power_on_n clears them.
`timescale 1ns/1ns
module nv_byte_access
    import nv_access_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int ATOMIC_COUNT = ATOMIC_TICKS,
    parameter int SPLIT_COUNT = SPLIT_TICKS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic power_on_n,
    input wire logic [5:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    input wire logic global_irq_enable,
    input wire logic osc_tick,
    output logic [7:0] io_rdata,
    output logic cpu_stall,
    output logic ready_irq
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
        logic arm;
        logic [2:0] arm_cnt;
        logic irq_en;
        logic [2:0] stall_cnt;
        logic stall;
        logic irq;
        logic [7:0] rdata;
    } core_t;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic busy;
        logic [1:0] mode;
        logic [1:0] op_mode;
        logic [AW-1:0] op_addr;
        logic [7:0] op_data;
        logic [15:0] ticks;
        logic [2:0] osc_sync;
        logic osc_level;
    } nvm_t;

    core_t core;
    core_t next_core;
    nvm_t nvm;
    nvm_t next_nvm;

    logic ctrl_write;
    logic start_go;
    logic read_go;
    logic [7:0] read_byte;
    logic [7:0] ctrl_view;

    assign ctrl_write = io_write && io_addr == REG_CONTROL;
    // Arm must still be set and the engine idle; reserved mode never starts
    assign start_go = ctrl_write && io_wdata[BIT_PROGRAM_STROBE] && core.arm
        && !nvm.busy && nvm.mode != MODE_RESERVED;
    assign read_go = ctrl_write && io_wdata[BIT_READ_STROBE] && !nvm.busy;
    assign read_byte = nvm.mem[core.addr[AW-1:0]];
    assign ctrl_view = {2'h0, nvm.mode, core.irq_en, core.arm, nvm.busy, 1'b0};

    always_comb begin
        next_core = core;
        if (io_write && io_addr == REG_ADDR_LOW && !nvm.busy) begin
            next_core.addr[7:0] = io_wdata;
        end
        if (io_write && io_addr == REG_ADDR_HIGH && !nvm.busy) begin
            next_core.addr[8] = io_wdata[0];
        end
        if (io_write && io_addr == REG_DATA) begin
            next_core.data = io_wdata;
        end
        if (ctrl_write) begin
            next_core.irq_en = io_wdata[BIT_READY_IRQ_ENABLE];
        end
        // Arm window counts down, then drops
        if (core.arm) begin
            if (core.arm_cnt == 3'h0) begin
                next_core.arm = 1'b0;
            end else begin
                next_core.arm_cnt = core.arm_cnt - 3'h1;
            end
        end
        if (ctrl_write && io_wdata[BIT_PROGRAM_ARM]) begin
            next_core.arm = 1'b1;
            next_core.arm_cnt = ARM_WINDOW_CYCLES - 3'h1;
        end
        if (core.stall_cnt != 3'h0) begin
            next_core.stall_cnt = core.stall_cnt - 3'h1;
        end
        if (start_go) begin
            // One armed strobe per arming
            next_core.arm = 1'b0;
            next_core.stall_cnt = PROG_STALL_CYCLES;
        end
        if (read_go) begin
            next_core.data = read_byte;
            next_core.stall_cnt = READ_STALL_CYCLES;
        end
        next_core.stall = next_core.stall_cnt != 3'h0;
        next_core.irq = next_core.irq_en && global_irq_enable && !next_nvm.busy;
        next_core.rdata = core.rdata;
        if (io_read) begin
            case (io_addr)
                REG_ADDR_HIGH: next_core.rdata = {7'h00, core.addr[8]};
                REG_ADDR_LOW: next_core.rdata = core.addr[7:0];
                REG_DATA: next_core.rdata = core.data;
                REG_CONTROL: next_core.rdata = ctrl_view;
                default: next_core.rdata = ZERO_BYTE;
            endcase
        end
    end

    always_comb begin
        next_nvm = nvm;
        // Oscillator tick: three stages, a change counts once stages 2 and 3 agree
        next_nvm.osc_sync = {nvm.osc_sync[1:0], osc_tick};
        if (nvm.osc_sync[1] == nvm.osc_sync[2]) begin
            next_nvm.osc_level = nvm.osc_sync[2];
        end
        if (ctrl_write && !nvm.busy) begin
            next_nvm.mode = io_wdata[BIT_PROG_MODE_HI:BIT_PROG_MODE_LO];
        end
        // Reset clears the mode only when idle, so a running operation keeps it
        if (!reset_n && !nvm.busy) begin
            next_nvm.mode = MODE_RESET;
        end
        if (nvm.busy) begin
            if (nvm.ticks == 16'h0000) begin
                case (nvm.op_mode)
                    MODE_ATOMIC: next_nvm.mem[nvm.op_addr] = nvm.op_data;
                    MODE_ERASE: next_nvm.mem[nvm.op_addr] = ERASED_BYTE;
                    // Bits can only be cleared; an unerased byte ends up garbled
                    MODE_WRITE: next_nvm.mem[nvm.op_addr] =
                        nvm.mem[nvm.op_addr] & nvm.op_data;
                    default: next_nvm.mem[nvm.op_addr] = nvm.mem[nvm.op_addr];
                endcase
                next_nvm.busy = 1'b0;
            end else if (nvm.osc_level && !next_nvm.osc_level) begin
                next_nvm.ticks = nvm.ticks - 16'h0001;
            end
        end
        if (start_go) begin
            next_nvm.busy = 1'b1;
            next_nvm.op_mode = nvm.mode;
            next_nvm.op_addr = core.addr[AW-1:0];
            next_nvm.op_data = core.data;
            next_nvm.ticks = (nvm.mode == MODE_ATOMIC) ? 16'(ATOMIC_COUNT)
                : 16'(SPLIT_COUNT);
        end
    end

    // CPU-side registers follow reset_n
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    // Engine and array follow only power-on, so reset_n cannot cut a write short
    always_ff @(posedge clock or negedge power_on_n) begin
        if (!power_on_n) begin
            nvm <= '0;
        end else begin
            nvm <= next_nvm;
        end
    end

    assign io_rdata = core.rdata;
    assign cpu_stall = core.stall;
    assign ready_irq = core.irq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n || !power_on_n);

    AST_READ_STALL: assert property (read_go |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");
    AST_PROG_STALL: assert property (start_go |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("program stall not two cycles");
    AST_SPLIT_TIME: assert property (start_go && nvm.mode != MODE_ATOMIC
        |=> nvm.ticks == 16'(SPLIT_COUNT))
        else $error("wrong split programming time");
    AST_MODE_HOLD: assert property (nvm.busy |=> $stable(nvm.mode))
        else $error("mode changed while programming");
    AST_IRQ_LEVEL: assert property (ready_irq |-> !nvm.busy && core.irq_en)
        else $error("ready interrupt while busy or disabled");
    AST_ARM_EXPIRE: assert property ($rose(core.arm) |-> ##4 !core.arm)
        else $error("arm bit outlived its window");
    AST_NO_UNARMED: assert property (ctrl_write && !core.arm |=> !$rose(nvm.busy))
        else $error("programming started without arm");
    AST_BUSY_END: assert property (nvm.busy && nvm.ticks == 16'h0000 |=> !nvm.busy)
        else $error("program strobe not cleared at end");
    AST_READ_DATA: assert property (read_go |=> core.data == $past(read_byte))
        else $error("read data not loaded");
    AST_ADDR_FROZEN: assert property (nvm.busy |=> $stable(core.addr))
        else $error("address changed while programming");
    AST_HIGH_ZERO: assert property (io_read && io_addr == REG_ADDR_HIGH
        |=> io_rdata[7:1] == 7'h00)
        else $error("reserved address bits not zero");

    // Programming engine: start, timing, a completion result for each of the three started modes, arming and ticks
    AST_ATOMIC_TIME: assert property (
        start_go && nvm.mode == MODE_ATOMIC
        |=> nvm.ticks == 16'(ATOMIC_COUNT))
        else $error("wrong atomic programming time");
    AST_ATOMIC_RESULT: assert property (
        nvm.busy && nvm.ticks == 16'h0000 && nvm.op_mode == MODE_ATOMIC
        |=> nvm.mem[nvm.op_addr] == nvm.op_data)
        else $error("atomic program did not store the data byte");
    AST_ERASE_RESULT: assert property (
        nvm.busy && nvm.ticks == 16'h0000 && nvm.op_mode == MODE_ERASE
        |=> nvm.mem[nvm.op_addr] == ERASED_BYTE)
        else $error("erase did not leave an erased byte");
    AST_WRITE_AND: assert property (
        nvm.busy && nvm.ticks == 16'h0000 && nvm.op_mode == MODE_WRITE
        |=> nvm.mem[nvm.op_addr] == ($past(nvm.mem[nvm.op_addr]) & nvm.op_data))
        else $error("write-only result is not old and new combined");
    AST_RSV_NO_START: assert property (
        ctrl_write && io_wdata[BIT_PROGRAM_STROBE] && nvm.mode == MODE_RESERVED
        |=> !$rose(nvm.busy))
        else $error("reserved mode started an operation");
    AST_MODE_WRITE: assert property (
        ctrl_write && !nvm.busy
        |=> nvm.mode == $past(io_wdata[BIT_PROG_MODE_HI:BIT_PROG_MODE_LO]))
        else $error("idle mode write not taken");
    AST_OP_CAPTURE: assert property (
        start_go
        |=> nvm.op_data == $past(core.data) && nvm.op_addr == $past(core.addr[AW-1:0]))
        else $error("operation did not capture address and data");
    AST_BUSY_HOLD: assert property (
        nvm.busy && nvm.ticks != 16'h0000
        |=> nvm.busy)
        else $error("program strobe dropped before time ran out");
    AST_ARM_NEEDED: assert property (
        $rose(nvm.busy)
        |-> $past(core.arm))
        else $error("operation started without a live arm bit");
    AST_ARM_SET: assert property (
        ctrl_write && io_wdata[BIT_PROGRAM_ARM] && !start_go
        |=> core.arm)
        else $error("arm write not taken");
    AST_STALL_REFUSED: assert property (
        ctrl_write && io_wdata[BIT_PROGRAM_STROBE] && !io_wdata[BIT_READ_STROBE]
        && !core.arm && !cpu_stall |=> !cpu_stall)
        else $error("refused strobe stalled the CPU");
    AST_TICK_IDLE: assert property (
        nvm.busy && nvm.ticks != 16'h0000 && !nvm.osc_level
        |=> $stable(nvm.ticks))
        else $error("programming time moved without an oscillator tick");
    AST_TICK_COUNT: assert property (
        nvm.busy && nvm.ticks != 16'h0000 && nvm.osc_level && nvm.osc_sync[2:1] == 2'b00
        |=> nvm.ticks == $past(nvm.ticks) - 16'h0001)
        else $error("oscillator tick not counted");

    // Ready interrupt as a level
    AST_IRQ_ON: assert property (
        core.irq_en && global_irq_enable && !nvm.busy && !ctrl_write
        |=> ready_irq)
        else $error("ready interrupt missing while idle and enabled");
    AST_IRQ_GLOBAL: assert property (
        !global_irq_enable
        |=> !ready_irq)
        else $error("ready interrupt with global enable clear");
    AST_IRQ_BUSY: assert property (
        $rose(nvm.busy)
        |-> !ready_irq)
        else $error("ready interrupt as programming starts");

    // Register file and readback
    AST_READ_ADDR: assert property (
        read_go
        |=> core.data == nvm.mem[$past(core.addr[AW-1:0])])
        else $error("read fetched the wrong location");
    AST_READ_REFUSED: assert property (
        nvm.busy && !(io_write && io_addr == REG_DATA)
        |=> $stable(core.data))
        else $error("data register changed by a read while programming");
    AST_DATA_WRITE: assert property (
        io_write && io_addr == REG_DATA
        |=> core.data == $past(io_wdata))
        else $error("data write not taken");
    AST_LOW_WRITE: assert property (
        io_write && io_addr == REG_ADDR_LOW && !nvm.busy
        |=> core.addr[7:0] == $past(io_wdata))
        else $error("low address write not taken");
    AST_HIGH_WRITE: assert property (
        io_write && io_addr == REG_ADDR_HIGH && !nvm.busy
        |=> core.addr[8] == $past(io_wdata[0]))
        else $error("high address write not taken");
    AST_READ_RDATA: assert property (
        io_read && io_addr == REG_DATA
        |=> io_rdata == $past(core.data))
        else $error("data register readback wrong");
    AST_CTRL_VIEW: assert property (
        io_read && io_addr == REG_CONTROL
        |=> io_rdata[BIT_PROGRAM_STROBE] == $past(nvm.busy))
        else $error("program strobe readback does not follow busy");

    // Engine checks run through reset_n; only power-on mutes them
    AST_MODE_RESET: assert property (disable iff (!power_on_n)
        !reset_n && !nvm.busy
        |=> nvm.mode == MODE_RESET)
        else $error("mode not cleared by reset while idle");
    AST_RESET_MODE: assert property (disable iff (!power_on_n)
        !reset_n && nvm.busy
        |=> $stable(nvm.mode))
        else $error("reset changed the mode of a running operation");
    AST_RESET_BUSY: assert property (disable iff (!power_on_n)
        !reset_n && nvm.busy && nvm.ticks != 16'h0000
        |=> nvm.busy)
        else $error("reset cut a running operation short");

    COV_READ: cover property (read_go ##5 !cpu_stall);
    COV_ATOMIC: cover property (start_go && nvm.mode == MODE_ATOMIC);
    COV_ERASE_DONE: cover property (nvm.busy && nvm.op_mode == MODE_ERASE ##1 !nvm.busy);
    COV_READ_REFUSED: cover property (ctrl_write && io_wdata[BIT_READ_STROBE] && nvm.busy);
    COV_WRITE_ONLY: cover property (nvm.busy && nvm.op_mode == MODE_WRITE ##1 !nvm.busy);
endmodule // nv_byte_access

// [testbench/cpu_bus_model.sv]
// Purpose: CPU-side bus master model for the EEPROM access block.
// Assumes: one-cycle strobes launched at the falling edge.
// Notes: Like a halted core, it waits out cpu_stall first.
`timescale 1ns/1ns
module cpu_bus_model
    import nv_access_pkg::*;
(
    input wire logic clock,
    input wire logic cpu_stall,
    input wire logic [7:0] io_rdata,
    output logic [5:0] io_addr,
    output logic io_write,
    output logic io_read,
    output logic [7:0] io_wdata
);
    initial begin
        io_write = 1'b0;
        io_read = 1'b0;
        io_addr = 6'h3F;
        io_wdata = 8'h00;
    end
    task automatic go();
        int n;
        n = 0;
        @(negedge clock);
        while (cpu_stall !== 1'b0 && n < 9) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        go();
        io_addr = a;
        io_wdata = d;
        io_write = 1'b1;
        @(negedge clock);
        io_write = 1'b0;
        io_wdata = ~d; // No stale data once released
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        go();
        io_addr = a;
        io_read = 1'b1;
        @(negedge clock);
        io_read = 1'b0;
        d = io_rdata;
    endtask
    task automatic set_addr(input logic [8:0] a);
        wr(REG_ADDR_HIGH, {7'h00, a[8]});
        wr(REG_ADDR_LOW, a[7:0]);
    endtask
    task automatic idle();
        logic [7:0] v;
        v = 8'hFF;
        for (int n = 0; n < 40 && v[1] !== 1'b0; n++) rd(REG_CONTROL, v);
    endtask
endmodule // cpu_bus_model

// [testbench/tb_top.sv]
// Purpose: Self-checking bench of the EEPROM access block.
// Assumes: program counts cut to 4 and 2 oscillator ticks.
// Notes: Ticks are driven by hand so busy time is exact.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top
    import nv_access_pkg::*;
;
    logic clock, reset_n, power_on_n, global_irq_enable, osc_tick;
    logic io_write, io_read, cpu_stall, ready_irq;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    logic [7:0] sh [0:511];
    int n_errors = 0;
    int n_checks = 0;
    int stall_cnt = 0;
    initial clock = 1'b0;
    always #25 clock = ~clock;
    always @(negedge clock) if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
    cpu_bus_model cpu (.clock, .cpu_stall, .io_rdata, .io_addr, .io_write, .io_read, .io_wdata);
    nv_byte_access #(.ATOMIC_COUNT(4), .SPLIT_COUNT(2)) dut (.clock, .reset_n,
        .power_on_n, .io_addr, .io_write, .io_read, .io_wdata, .global_irq_enable, .osc_tick,
        .io_rdata, .cpu_stall, .ready_irq);
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(negedge clock);
            osc_tick = 1'b1;
            repeat (4) @(negedge clock);
            osc_tick = 1'b0;
        end
        repeat (6) @(negedge clock);
    endtask
    task automatic start(input logic [1:0] m, input logic [7:0] d);
        cpu.wr(REG_CONTROL, {2'h0, m, 4'h8});
        cpu.wr(REG_DATA, d);
        cpu.wr(REG_CONTROL, {2'h0, m, 4'hC});
        cpu.wr(REG_CONTROL, {2'h0, m, 4'hA});
    endtask
    task automatic pulse();
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
    endtask
    task automatic prog(input logic [8:0] a, input logic [1:0] m, input logic [7:0] d,
        input int n);
        logic [7:0] r;
        logic [7:0] e;
        int s0;
        e = (m == MODE_ATOMIC) ? d : (m == MODE_ERASE) ? ERASED_BYTE : sh[a];
        e = (m == MODE_WRITE) ? (sh[a] & d) : e;
        cpu.set_addr(a);
        s0 = stall_cnt;
        start(m, d);
        cpu.rd(REG_CONTROL, r);
        `CHK(stall_cnt - s0, (n > 0) ? 2 : 0)
        `CHK(r[BIT_PROGRAM_STROBE], n > 0)
        if (n > 0) begin
            `CHK(ready_irq, 1'b0)
            cpu.wr(REG_ADDR_LOW, ~a[7:0]);
            cpu.wr(REG_CONTROL, {2'h0, ~m, 4'h9});
            cpu.rd(REG_ADDR_LOW, r);
            `CHK(r, a[7:0])
            cpu.rd(REG_DATA, r);
            `CHK(r, d)
            ticks(n - 1);
            cpu.rd(REG_CONTROL, r);
            `CHK(r[BIT_PROGRAM_STROBE], 1'b1)
            ticks(1);
        end
        cpu.idle();
        cpu.rd(REG_CONTROL, r);
        `CHK(r[BIT_PROGRAM_STROBE], 1'b0)
        `CHK(r[5:4], m)
        `CHK(ready_irq, 1'b1)
        s0 = stall_cnt;
        cpu.wr(REG_CONTROL, {2'h0, m, 4'h9});
        cpu.rd(REG_DATA, r);
        `CHK(r, e)
        `CHK(stall_cnt - s0, 4)
        sh[a] = e;
    endtask
    initial begin
        #1_000_000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        power_on_n = 1'b0;
        global_irq_enable = 1'b1;
        osc_tick = 1'b0;
        for (int i = 0; i < 512; i++) sh[i] = ZERO_BYTE;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        power_on_n = 1'b1;
        cpu.set_addr(9'h1A5);
        cpu.wr(REG_ADDR_HIGH, 8'hFF);
        cpu.rd(REG_ADDR_HIGH, v);
        `CHK(v, 8'h01)
        cpu.rd(REG_ADDR_LOW, v);
        `CHK(v, 8'hA5)
        $display("address test done");
        prog(9'h1A5, MODE_ATOMIC, 8'h3C, 4);
        prog(9'h1A5, MODE_ERASE, 8'h00, 2);
        prog(9'h1A5, MODE_WRITE, 8'h5A, 2);
        prog(9'h0A5, MODE_ATOMIC, 8'h77, 4);
        prog(9'h1A5, MODE_WRITE, 8'hF0, 2);
        prog(9'h1A5, MODE_RESERVED, 8'h11, 0);
        $display("mode test done");
        cpu.wr(REG_CONTROL, 8'h0C);
        cpu.rd(REG_CONTROL, v);
        `CHK(v[BIT_PROGRAM_ARM], 1'b1)
        repeat (4) @(negedge clock);
        cpu.rd(REG_CONTROL, v);
        `CHK(v[BIT_PROGRAM_ARM], 1'b0)
        cpu.wr(REG_CONTROL, 8'h0A);
        cpu.rd(REG_CONTROL, v);
        `CHK(v[BIT_PROGRAM_STROBE], 1'b0)
        global_irq_enable = 1'b0;
        @(negedge clock);
        `CHK(ready_irq, 1'b0)
        global_irq_enable = 1'b1;
        $display("arm test done");
        cpu.set_addr(9'h033);
        start(MODE_ERASE, 8'h00);
        pulse();
        cpu.rd(REG_CONTROL, v);
        `CHK(v[5:4], MODE_ERASE)
        `CHK(v[BIT_PROGRAM_STROBE], 1'b1)
        ticks(2);
        cpu.idle();
        cpu.set_addr(9'h033);
        cpu.wr(REG_CONTROL, 8'h01);
        cpu.rd(REG_DATA, v);
        `CHK(v, ERASED_BYTE)
        cpu.wr(REG_CONTROL, 8'h20);
        pulse();
        cpu.rd(REG_CONTROL, v);
        `CHK(v[5:4], MODE_RESET)
        $display("reset test done");
        cpu.wr(REG_CONTROL, 8'h20);
        power_on_n = 1'b0;
        @(negedge clock);
        power_on_n = 1'b1;
        cpu.rd(REG_CONTROL, v);
        `CHK(v[5:4], MODE_RESET)
        cpu.set_addr(9'h1A5);
        cpu.wr(REG_CONTROL, 8'h01);
        cpu.rd(REG_DATA, v);
        `CHK(v, ZERO_BYTE)
        $display("power-on test done");
        tally_and_finish();
    end
endmodule // tb_top
